/* supervisor_consts.svh */
`ifndef SUPERVISOR_CONSTS_SVH
`define SUPERVISOR_CONSTS_SVH

// system clock
`define CLK_PERIOD_NS 20
// reset stretch after last cause clears
`define STRETCH_MS 200
`define STRETCH_CYCLES ((`STRETCH_MS * 1000000) / `CLK_PERIOD_NS)
// nominal watchdog timeout
`define WD_TIMEOUT_MS 1600
`define WD_TIMEOUT_CYCLES ((`WD_TIMEOUT_MS * 1000000) / `CLK_PERIOD_NS)
// alternative timeout when timeout_select is capacitor-set
`define WD_ALT_TIMEOUT_MS 100
`define WD_ALT_TIMEOUT_CYCLES ((`WD_ALT_TIMEOUT_MS * 1000000) / `CLK_PERIOD_NS)
// watchdog pulse width
`define WD_PULSE_US 1700
`define WD_PULSE_CYCLES ((`WD_PULSE_US * 1000) / `CLK_PERIOD_NS)
// fault follows pulse fall
`define WD_FAULT_DELAY_NS 70
`define WD_FAULT_DELAY_CYCLES ((`WD_FAULT_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// minimum kick pulse
`define KICK_MIN_NS 100
`define KICK_MIN_CYCLES ((`KICK_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// chip-enable grace after reset asserts
`define CE_GRACE_US 15
`define CE_GRACE_CYCLES ((`CE_GRACE_US * 1000) / `CLK_PERIOD_NS)
// counter width, holds the largest count
`define CNT_W 27

`endif

/* supervisor_pkg.sv */
package supervisor_pkg;
    // digitised comparator results
    typedef struct packed {
        logic mode_ext;
        logic int_low;
        logic int_reset;
        logic ext_low;
        logic ext_reset;
        logic manual_low;
        logic over_v;
        logic tsel_cap;
    } comp_t;

    // active-level watchdog outputs
    typedef struct packed {
        logic fault_n;
        logic pulse_n;
    } wd_out_t;

    typedef enum logic [1:0] {
        WD_RUN = 2'b00,
        WD_PULSE = 2'b01,
        WD_FAULT = 2'b10
    } wd_state_t;
endpackage

/* sync2.sv */
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // data
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // sync2

/* watchdog_core.sv */
`timescale 1ns/1ps
`include "supervisor_consts.svh"
module watchdog_core (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // control
    input wire logic hold,
    input wire logic kick,
    input wire logic alt_period,
    // outputs
    output supervisor_pkg::wd_out_t wd
);
    import supervisor_pkg::*;

    localparam logic [`CNT_W-1:0] TO_NOM = `CNT_W'(`WD_TIMEOUT_CYCLES);
    localparam logic [`CNT_W-1:0] TO_ALT = `CNT_W'(`WD_ALT_TIMEOUT_CYCLES);
    localparam logic [`CNT_W-1:0] PULSE = `CNT_W'(`WD_PULSE_CYCLES);
    localparam logic [`CNT_W-1:0] FDLY = `CNT_W'(`WD_FAULT_DELAY_CYCLES);

    wd_state_t state_q;
    logic [`CNT_W-1:0] cnt_q;
    logic fault_q;
    logic [`CNT_W-1:0] limit;

    assign limit = alt_period ? TO_ALT : TO_NOM;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= WD_RUN;
            cnt_q <= '0;
        end else if (hold) begin
            state_q <= WD_RUN;
            cnt_q <= '0;
        end else if (kick && state_q != WD_PULSE) begin
            state_q <= WD_RUN;
            cnt_q <= '0;
        end else begin
            unique case (state_q)
                WD_RUN: begin
                    if (cnt_q >= limit - 1'b1) begin
                        state_q <= WD_PULSE;
                        cnt_q <= '0;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                WD_PULSE: begin
                    if (cnt_q >= PULSE - 1'b1) begin
                        state_q <= WD_FAULT;
                        cnt_q <= '0;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                WD_FAULT: begin
                    // next timeout period runs while fault stays low
                    if (cnt_q >= limit - 1'b1) begin
                        state_q <= WD_PULSE;
                        cnt_q <= '0;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                default: begin
                    state_q <= WD_RUN;
                    cnt_q <= '0;
                end
            endcase
        end
    end

    // fault drops a short delay after pulse falls, clears on kick or hold;
    // timed from the pulse start so a kick from cnt_q == FDLY - 1 on in the pulse stays cleared
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            fault_q <= 1'b0;
        end else if (hold || kick) begin
            fault_q <= 1'b0;
        end else if (state_q == WD_PULSE && cnt_q == FDLY - 1'b1) begin
            fault_q <= 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wd <= '{fault_n: 1'b1, pulse_n: 1'b1};
        end else begin
            wd.pulse_n <= !(state_q == WD_PULSE && !hold);
            wd.fault_n <= !(fault_q && !hold);
        end
    end
endmodule // watchdog_core

/* supply_supervisor_watchdog.sv */
`timescale 1ns/1ps
`include "supervisor_consts.svh"
module supply_supervisor_watchdog (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // digitised comparator results, asynchronous
    input supervisor_pkg::comp_t comp_in,
    // processor kick line, asynchronous
    input wire logic watchdog_kick_in,
    // chip-enable path
    input wire logic chip_enable_in_n,
    output logic chip_enable_out_n,
    output logic chip_enable_in_oe,
    // supervisor outputs
    output logic supply_warning_n,
    output logic reset_out,
    output logic reset_out_n,
    output logic overvoltage_flag_n,
    output logic watchdog_fault_n,
    output logic watchdog_pulse_n
);
    import supervisor_pkg::*;

    localparam logic [`CNT_W-1:0] STRETCH = `CNT_W'(`STRETCH_CYCLES);
    localparam logic [`CNT_W-1:0] GRACE = `CNT_W'(`CE_GRACE_CYCLES);
    localparam logic [`CNT_W-1:0] KMIN = `CNT_W'(`KICK_MIN_CYCLES);

    comp_t comp_s;
    logic mode_ext_s;
    logic int_low_s;
    logic int_reset_s;
    logic ext_low_s;
    logic ext_reset_s;
    logic manual_low_s;
    logic over_v_s;
    logic tsel_cap_s;
    logic kick_s;
    logic ce_in_s;
    logic kick_prev_q;
    logic [`CNT_W-1:0] kwidth_q;
    logic kick_evt;
    logic supply_low;
    logic supply_low_q;
    logic supply_cause;
    logic warn_low;
    logic cause;
    logic [`CNT_W-1:0] stretch_q;
    logic stretch_done;
    logic rst_q;
    logic rst_prev_q;
    logic rst_rise;
    logic [`CNT_W-1:0] grace_q;
    logic grace_q_act;
    logic grace_start;
    logic gate_open;
    logic wd_hold;
    wd_out_t wd;

    // one two-flop stage per input, so an input can gain a filter
    // or move without disturbing the others
    sync2 #(.W(1)) u_sync_mode (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .async_in(comp_in.mode_ext),
        .sync_out(mode_ext_s)
    );

    sync2 #(.W(1)) u_sync_int_low (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .async_in(comp_in.int_low),
        .sync_out(int_low_s)
    );

    sync2 #(.W(1)) u_sync_int_reset (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .async_in(comp_in.int_reset),
        .sync_out(int_reset_s)
    );

    sync2 #(.W(1)) u_sync_ext_low (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .async_in(comp_in.ext_low),
        .sync_out(ext_low_s)
    );

    sync2 #(.W(1)) u_sync_ext_reset (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .async_in(comp_in.ext_reset),
        .sync_out(ext_reset_s)
    );

    sync2 #(.W(1)) u_sync_manual (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .async_in(comp_in.manual_low),
        .sync_out(manual_low_s)
    );

    sync2 #(.W(1)) u_sync_over_v (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .async_in(comp_in.over_v),
        .sync_out(over_v_s)
    );

    sync2 #(.W(1)) u_sync_tsel (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .async_in(comp_in.tsel_cap),
        .sync_out(tsel_cap_s)
    );

    sync2 #(.W(1)) u_sync_kick (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .async_in(watchdog_kick_in),
        .sync_out(kick_s)
    );

    sync2 #(.W(1)) u_sync_ce_in (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .async_in(chip_enable_in_n),
        .sync_out(ce_in_s)
    );

    // comparator results regrouped after synchronisation
    assign comp_s = '{
        mode_ext: mode_ext_s,
        int_low: int_low_s,
        int_reset: int_reset_s,
        ext_low: ext_low_s,
        ext_reset: ext_reset_s,
        manual_low: manual_low_s,
        over_v: over_v_s,
        tsel_cap: tsel_cap_s
    };

    // threshold mode select
    assign supply_low = comp_s.mode_ext ? comp_s.ext_reset : comp_s.int_reset;
    // internal warning threshold sits above reset, so it also covers reset
    assign warn_low = comp_s.mode_ext ? comp_s.ext_low
                                      : (comp_s.int_low | comp_s.int_reset);
    // internal mode: reset lags the warning one cycle, so the warning leads
    // even when both comparators trip in the same cycle
    assign supply_cause = comp_s.mode_ext ? supply_low : supply_low_q;
    assign cause = supply_cause | comp_s.manual_low;

    // warning output registered
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            supply_warning_n <= 1'b1;
        end else begin
            supply_warning_n <= !warn_low;
        end
    end

    // delayed supply cause for the internal-mode ordering
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            supply_low_q <= 1'b0;
        end else begin
            supply_low_q <= supply_low;
        end
    end

    assign stretch_done = rst_q && (stretch_q >= STRETCH - 1'b1);

    // stretch counter; runs only once every cause is gone
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            stretch_q <= '0;
        end else if (cause) begin
            stretch_q <= '0;
        end else if (rst_q && !stretch_done) begin
            stretch_q <= stretch_q + 1'b1;
        end
    end

    // reset level: any cause sets it, a full stretch clears it
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rst_q <= 1'b1;
        end else if (cause) begin
            rst_q <= 1'b1;
        end else if (stretch_done) begin
            rst_q <= 1'b0;
        end
    end

    assign reset_out = rst_q;
    assign reset_out_n = !rst_q;

    // overvoltage flag, touches nothing else
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            overvoltage_flag_n <= 1'b1;
        end else begin
            overvoltage_flag_n <= !comp_s.over_v;
        end
    end

    // kick line history
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            kick_prev_q <= 1'b0;
        end else begin
            kick_prev_q <= kick_s;
        end
    end

    // kick: any edge, but an edge whose new level lasts less than the minimum is ignored
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            kwidth_q <= '0;
        end else if (kick_s != kick_prev_q) begin
            kwidth_q <= '0;
        end else if (kwidth_q < KMIN) begin
            kwidth_q <= kwidth_q + 1'b1;
        end
    end

    // level held past the minimum after a change counts as a kick
    assign kick_evt = (kick_s == kick_prev_q) && (kwidth_q == KMIN - 1'b1);

    // watchdog sleeps through reset and through any low supply
    assign wd_hold = rst_q | supply_low;

    watchdog_core u_wd (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .hold(wd_hold),
        .kick(kick_evt),
        .alt_period(comp_s.tsel_cap),
        .wd(wd)
    );

    assign watchdog_fault_n = wd.fault_n;
    assign watchdog_pulse_n = wd.pulse_n;

    // reset rising edge; reset value matches reset_out so no false edge
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rst_prev_q <= 1'b1;
        end else begin
            rst_prev_q <= rst_q;
        end
    end

    assign rst_rise = rst_q && !rst_prev_q;
    assign grace_start = rst_rise && !ce_in_s;

    // grace window lets a write in progress finish
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            grace_q_act <= 1'b0;
        end else if (grace_start) begin
            grace_q_act <= 1'b1;
        end else if (grace_q_act && (ce_in_s || !rst_q || grace_q >= GRACE - 1'b1)) begin
            grace_q_act <= 1'b0;
        end
    end

    // grace length counter
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            grace_q <= '0;
        end else if (grace_start) begin
            grace_q <= '0;
        end else if (grace_q_act) begin
            grace_q <= grace_q + 1'b1;
        end
    end

    // grace_start keeps the gate open in the cycle before grace_q_act rises
    assign gate_open = !rst_q || grace_q_act || grace_start;

    // disabled: output pulled high
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            chip_enable_out_n <= 1'b1;
        end else begin
            chip_enable_out_n <= gate_open ? ce_in_s : 1'b1;
        end
    end

    // input never driven, so it floats whenever the gate is disabled
    assign chip_enable_in_oe = 1'b0;
endmodule // supply_supervisor_watchdog

/* supervisor_asserts.sv */
`timescale 1ns/1ps
module supervisor_asserts (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // inputs
    input supervisor_pkg::comp_t comp_in,
    input wire logic chip_enable_in_n,
    // outputs
    input wire logic chip_enable_out_n,
    input wire logic chip_enable_in_oe,
    input wire logic supply_warning_n,
    input wire logic reset_out,
    input wire logic reset_out_n,
    input wire logic overvoltage_flag_n,
    input wire logic watchdog_fault_n,
    input wire logic watchdog_pulse_n
);
    import supervisor_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // repetitions of five cover the sync and register latency
    a_rst_compl: assert property (reset_out == !reset_out_n)
        else $error("reset pair not complementary");
    a_ov_set: assert property (comp_in.over_v [*5] |-> !overvoltage_flag_n)
        else $error("overvoltage flag not low");
    a_ov_clear: assert property (!comp_in.over_v [*5] |-> overvoltage_flag_n)
        else $error("overvoltage flag not high");
    a_supply_rst: assert property ((comp_in.mode_ext ? comp_in.ext_reset : comp_in.int_reset)
        [*5] |-> reset_out)
        else $error("low supply without reset");
    a_manual_rst: assert property (comp_in.manual_low [*5] |-> reset_out)
        else $error("manual request without reset");
    a_warn_int: assert property ((!comp_in.mode_ext && (comp_in.int_low || comp_in.int_reset))
        [*5] |-> !supply_warning_n)
        else $error("internal warning missing");
    a_warn_ext: assert property ((comp_in.mode_ext && comp_in.ext_low) [*5]
        |-> !supply_warning_n)
        else $error("external warning missing");
    a_warn_high: assert property ((!comp_in.mode_ext && !comp_in.int_low && !comp_in.int_reset)
        [*5] |-> supply_warning_n)
        else $error("warning low on normal supply");
    a_wd_quiet: assert property (reset_out [*2] |-> watchdog_fault_n && watchdog_pulse_n)
        else $error("watchdog active in reset");
    a_ce_gate: assert property ((reset_out && chip_enable_in_n) [*5] |-> chip_enable_out_n)
        else $error("chip enable passed in reset");
    a_no_drive: assert property (!chip_enable_in_oe)
        else $error("chip enable input driven");
    a_fault_pulse: assert property ($fell(watchdog_fault_n) |-> !watchdog_pulse_n)
        else $error("fault without pulse");
    a_pulse_min: assert property ($fell(watchdog_pulse_n)
        |=> (!watchdog_pulse_n || reset_out) [*8])
        else $error("watchdog pulse too short");
endmodule // supervisor_asserts

bind supply_supervisor_watchdog supervisor_asserts chk_u (
    .mclk(mclk), .sys_rst(sys_rst), .comp_in(comp_in), .chip_enable_in_n(chip_enable_in_n),
    .chip_enable_out_n(chip_enable_out_n), .chip_enable_in_oe(chip_enable_in_oe),
    .supply_warning_n(supply_warning_n), .reset_out(reset_out), .reset_out_n(reset_out_n),
    .overvoltage_flag_n(overvoltage_flag_n), .watchdog_fault_n(watchdog_fault_n),
    .watchdog_pulse_n(watchdog_pulse_n)
);

/* host_model.sv */
`timescale 1ns/1ps
module host_model (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // commands from the bench
    input wire logic kick_en,
    input wire logic ce_req,
    // lines toward the supervisor
    output logic watchdog_kick_in,
    output logic chip_enable_in_n
);
    logic [2:0] div_q = 3'h0;
    // toggle every 8 cycles, wider than the 5-cycle minimum kick width
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            div_q <= 3'h0;
            watchdog_kick_in <= 1'b0;
        end else begin
            div_q <= div_q + 3'h1;
            if (kick_en && div_q == 3'h7) begin
                watchdog_kick_in <= !watchdog_kick_in;
            end
        end
    end
    // memory select, active low
    always @(posedge mclk) begin
        chip_enable_in_n <= !ce_req;
    end
endmodule // host_model

/* supply_supervisor_watchdog_tb.sv */
`timescale 1ns/1ps
module supply_supervisor_watchdog_tb;
    import supervisor_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    comp_t comp_in = '0;
    logic kick_en = 1'b0;
    logic ce_req = 1'b0;
    logic kick, ce_in_n, ce_out_n, ce_oe, warn_n, rst_o, rst_o_n, ov_n, fault_n, pulse_n;
    int err_count = 0;
    int samples_checked = 0;

    initial begin
        forever #10 mclk = ~mclk;
    end

    supply_supervisor_watchdog dut_u (
        .mclk(mclk), .sys_rst(sys_rst), .comp_in(comp_in), .watchdog_kick_in(kick),
        .chip_enable_in_n(ce_in_n), .chip_enable_out_n(ce_out_n), .chip_enable_in_oe(ce_oe),
        .supply_warning_n(warn_n), .reset_out(rst_o), .reset_out_n(rst_o_n),
        .overvoltage_flag_n(ov_n), .watchdog_fault_n(fault_n), .watchdog_pulse_n(pulse_n)
    );

    host_model host_u (
        .mclk(mclk), .sys_rst(sys_rst), .kick_en(kick_en), .ce_req(ce_req),
        .watchdog_kick_in(kick), .chip_enable_in_n(ce_in_n)
    );

    task automatic check(input string name, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s exp %b got %b", name, exp, got);
        end
    endtask

    task automatic report_and_stop;
        if (err_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // stretch keeps reset up for the whole run, so these always hold
    task automatic common;
        check("reset_out", 1'b1, rst_o);
        check("reset_out_n", 1'b0, rst_o_n);
        check("fault_n", 1'b1, fault_n);
        check("pulse_n", 1'b1, pulse_n);
        check("ce_out_n", 1'b1, ce_out_n);
        check("ce_oe", 1'b0, ce_oe);
    endtask

    task automatic apply(input comp_t c);
        logic w;
        w = c.mode_ext ? !c.ext_low : !(c.int_low || c.int_reset);
        @(posedge mclk);
        comp_in <= c;
        repeat (5) @(posedge mclk);
        #1;
        check("warn_n", w, warn_n);
        check("ov_n", !c.over_v, ov_n);
        common();
    endtask

    // each mode with the other mode's comparators set
    task automatic t_modes;
        apply(8'h40);
        apply(8'h20);
        apply(8'h18);
        apply(8'h90);
        apply(8'hE0);
        apply(8'h04);
        apply(8'h01);
    endtask

    task automatic t_overv;
        apply(8'h02);
        apply(8'h42);
        apply(8'h00);
    endtask

    // memory selects and kicks while reset is held
    task automatic t_gate;
        @(posedge mclk);
        kick_en <= 1'b1;
        comp_in <= 8'h20;
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            ce_req <= 1'b1;
            repeat (6) @(posedge mclk);
            #1;
            common();
            @(posedge mclk);
            ce_req <= 1'b0;
        end
    endtask

    initial begin
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        #1;
        common();
        t_modes();
        t_overv();
        t_gate();
        report_and_stop();
    end

    initial begin
        repeat (5000) @(posedge mclk);
        err_count++;
        report_and_stop();
    end
endmodule // supply_supervisor_watchdog_tb
